// ### hdl/acrs_pkg.sv
// Package of constants for the channel range sequencer.
package acrs_pkg;
   // ==========================================================
   // Register map
   localparam logic [11:0] ACRS_OFF_CTRL = 12'h000;
   localparam logic [11:0] ACRS_OFF_SCAN_EN = 12'h004;
   localparam logic [11:0] ACRS_OFF_MAN_CMD = 12'h008;
   localparam logic [11:0] ACRS_OFF_STATUS = 12'h00C;
   localparam logic [11:0] ACRS_OFF_RATE = 12'h010;
   localparam logic [11:0] ACRS_OFF_RANGE0 = 12'h020;
   localparam int ACRS_RANGE_STRIDE = 4;
   // ==========================================================
   // Field layout
   localparam int ACRS_CTRL_AUTO_BIT = 0;
   localparam int ACRS_STAT_CH_LSB = 0;
   localparam int ACRS_STAT_AUTO_BIT = 4;
   localparam int ACRS_STAT_REF_BIT = 5;
   localparam int ACRS_STAT_SAT_BIT = 6;
   localparam int ACRS_STAT_NSEL_LSB = 8;
   localparam int ACRS_RANGE_W = 4;
   // ==========================================================
   // Range codes
   localparam logic [3:0] ACRS_RNG_BI_2P5 = 4'h0;
   localparam logic [3:0] ACRS_RNG_BI_1P25 = 4'h1;
   localparam logic [3:0] ACRS_RNG_BI_0P625 = 4'h2;
   localparam logic [3:0] ACRS_RNG_UNI_2P5 = 4'h5;
   localparam logic [3:0] ACRS_RNG_UNI_1P25 = 4'h6;
   localparam logic [3:0] ACRS_RNG_RESET = ACRS_RNG_BI_2P5;
   // ==========================================================
   // Conversion data and rate
   localparam int ACRS_CODE_W = 18;
   localparam int ACRS_TOTAL_KSPS = 500;
   typedef enum logic [2:0]
   {
      ACRS_GAIN_X2P5 = 3'h1,
      ACRS_GAIN_X1P25 = 3'h2,
      ACRS_GAIN_X0P625 = 3'h4
   } acrs_scale_t;
endpackage : acrs_pkg

// ### hdl/acrs_sequencer.sv
// Channel range store and scan sequencer with an AHB-Lite register slave.
//
// The AHB-Lite interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ps
module acrs_sequencer
#(
   parameter int NUM_CH = 8,
   parameter int CH_W = 3
)
(
   // AHB-Lite slave
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Converter front end
   input wire logic cs_n,
   input wire logic reference_source_pin,
   input wire logic conv_valid,
   input wire logic [acrs_pkg::ACRS_CODE_W-1:0] conv_raw,
   input wire logic conv_over,
   input wire logic conv_under,
   output logic [CH_W-1:0] mux_channel,
   output logic [acrs_pkg::ACRS_RANGE_W-1:0] channel_range_code,
   output logic range_unipolar,
   output logic [2:0] range_scale,
   output logic use_external_ref,
   output logic [acrs_pkg::ACRS_CODE_W-1:0] conv_code,
   output logic conv_code_valid
);
   import acrs_pkg::*;

   // ==========================================================
   // Pin synchronisers
   logic cs_m_r, cs_s_r, cs_d_r;
   logic ref_m_r, ref_s_r;
   // The third chip-select flop only delays the synchronised level for edge detection.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         cs_m_r <= 1'b1;
         cs_s_r <= 1'b1;
         cs_d_r <= 1'b1;
         ref_m_r <= 1'b0;
         ref_s_r <= 1'b0;
      end
      else
      begin
         cs_m_r <= cs_n;
         cs_s_r <= cs_m_r;
         cs_d_r <= cs_s_r;
         ref_m_r <= reference_source_pin;
         ref_s_r <= ref_m_r;
      end
   end

   // A fall shows two edges after the pin drops; a low shorter than a clock can be missed.
   logic cs_fall;
   assign cs_fall = cs_d_r & ~cs_s_r;
   // The reference select is a board strap, so a level synchroniser is all that it needs.
   assign use_external_ref = ref_s_r;

   // ==========================================================
   // AHB-Lite address phase capture
   logic wr_pend_r, wr_pend_nxt;
   logic [11:0] addr_r, addr_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic take;
   // Only NONSEQ or SEQ slots are taken; IDLE and BUSY slots start no access and load zero read data, though an earlier write's data phase still lands.
   assign take = hsel & hready & htrans[1];
   // Every access completes with zero wait states, so the slave never stalls or errors.
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = rdata_r;

   // ==========================================================
   // Registers
   logic [ACRS_RANGE_W-1:0] range_r [NUM_CH];
   logic [ACRS_RANGE_W-1:0] range_nxt [NUM_CH];
   logic auto_r, auto_nxt;
   logic [NUM_CH-1:0] scan_en_r, scan_en_nxt;
   logic [CH_W-1:0] man_ch_r, man_ch_nxt;
   logic [CH_W-1:0] ch_r, ch_nxt;
   logic sat_r, sat_nxt;
   logic [ACRS_CODE_W-1:0] code_r, code_nxt;
   logic code_v_r, code_v_nxt;
   // The enabled count needs one bit more than a channel number to reach NUM_CH.
   logic [CH_W:0] nsel;
   logic [CH_W-1:0] next_scan;
   logic wr_now;

   // Population count of enabled channels.
   always_comb
   begin
      nsel = '0;
      for (int i = 0; i < NUM_CH; i++)
         nsel = nsel + {{CH_W{1'b0}}, scan_en_r[i]};
   end

   // Next enabled channel above the current one, wrapping to the lowest.
   // With no channel enabled the current channel is held rather than cleared.
   always_comb
   begin
      logic found;
      found = 1'b0;
      next_scan = ch_r;
      for (int i = 0; i < NUM_CH; i++)
         if (!found && scan_en_r[i] && CH_W'(i) > ch_r)
         begin
            next_scan = CH_W'(i);
            found = 1'b1;
         end
      for (int i = 0; i < NUM_CH; i++)
         if (!found && scan_en_r[i])
         begin
            next_scan = CH_W'(i);
            found = 1'b1;
         end
   end

   // A write lands at the end of its data phase, the only cycle in which hwdata stands.
   assign wr_now = wr_pend_r;

   always_comb
   begin
      wr_pend_nxt = take & hwrite;
      // The address is held past its phase so that the data-phase write can decode it.
      addr_nxt = take ? haddr[11:0] : addr_r;
      auto_nxt = auto_r;
      scan_en_nxt = scan_en_r;
      man_ch_nxt = man_ch_r;
      ch_nxt = ch_r;
      for (int i = 0; i < NUM_CH; i++)
         range_nxt[i] = range_r[i];
      if (wr_now)
      begin
         if (addr_r == ACRS_OFF_CTRL)
            auto_nxt = hwdata[ACRS_CTRL_AUTO_BIT];
         else if (addr_r == ACRS_OFF_SCAN_EN)
            scan_en_nxt = hwdata[NUM_CH-1:0];
         else if (addr_r == ACRS_OFF_MAN_CMD)
            man_ch_nxt = hwdata[CH_W-1:0];
         // Range writes keep only the low nibble; the upper data bits are ignored.
         for (int i = 0; i < NUM_CH; i++)
            if (addr_r == ACRS_OFF_RANGE0 + 12'(i * ACRS_RANGE_STRIDE))
               range_nxt[i] = hwdata[ACRS_RANGE_W-1:0];
      end
      // A command written in the cycle of a fall takes effect at the following fall.
      if (cs_fall)
      begin
         if (auto_r)
            ch_nxt = next_scan;
         else
            ch_nxt = man_ch_r;
      end
      // Read data is formed from the address phase so it stands in the data phase.
      rdata_nxt = '0;
      if (take && !hwrite)
      begin
         if (haddr[11:0] == ACRS_OFF_CTRL)
            rdata_nxt[ACRS_CTRL_AUTO_BIT] = auto_r;
         else if (haddr[11:0] == ACRS_OFF_SCAN_EN)
            rdata_nxt[NUM_CH-1:0] = scan_en_r;
         else if (haddr[11:0] == ACRS_OFF_MAN_CMD)
            rdata_nxt[CH_W-1:0] = man_ch_r;
         // Status packs the live channel, mode, strap, last saturation and enabled count.
         else if (haddr[11:0] == ACRS_OFF_STATUS)
         begin
            rdata_nxt[ACRS_STAT_CH_LSB +: CH_W] = ch_r;
            rdata_nxt[ACRS_STAT_AUTO_BIT] = auto_r;
            rdata_nxt[ACRS_STAT_REF_BIT] = ref_s_r;
            rdata_nxt[ACRS_STAT_SAT_BIT] = sat_r;
            rdata_nxt[ACRS_STAT_NSEL_LSB +: CH_W+1] = nsel;
         end
         // The rate is given in kSPS and reads zero while the scan list is empty.
         else if (haddr[11:0] == ACRS_OFF_RATE)
            rdata_nxt = (nsel == '0) ? 32'h0000_0000
                        : 32'(ACRS_TOTAL_KSPS) / 32'(nsel);
         // Unmapped offsets match nothing here and read as zero.
         for (int i = 0; i < NUM_CH; i++)
            if (haddr[11:0] == ACRS_OFF_RANGE0 + 12'(i * ACRS_RANGE_STRIDE))
               rdata_nxt[ACRS_RANGE_W-1:0] = range_r[i];
      end
   end

   // Range codes come up at the widest bipolar range so that no input is overdriven.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_pend_r <= 1'b0;
         addr_r <= '0;
         rdata_r <= '0;
         auto_r <= 1'b0;
         scan_en_r <= '0;
         man_ch_r <= '0;
         ch_r <= '0;
         for (int i = 0; i < NUM_CH; i++)
            range_r[i] <= ACRS_RNG_RESET;
      end
      else
      begin
         wr_pend_r <= wr_pend_nxt;
         addr_r <= addr_nxt;
         rdata_r <= rdata_nxt;
         auto_r <= auto_nxt;
         scan_en_r <= scan_en_nxt;
         man_ch_r <= man_ch_nxt;
         ch_r <= ch_nxt;
         for (int i = 0; i < NUM_CH; i++)
            range_r[i] <= range_nxt[i];
      end
   end

   // ==========================================================
   // Range decode for the selected channel
   // Decode is combinational so the range follows a channel change in the same cycle.
   assign mux_channel = ch_r;
   assign channel_range_code = range_r[ch_r];
   always_comb
   begin
      range_unipolar = 1'b0;
      range_scale = ACRS_GAIN_X2P5;
      case (channel_range_code)
         ACRS_RNG_BI_2P5: range_scale = ACRS_GAIN_X2P5;
         ACRS_RNG_BI_1P25: range_scale = ACRS_GAIN_X1P25;
         ACRS_RNG_BI_0P625: range_scale = ACRS_GAIN_X0P625;
         ACRS_RNG_UNI_2P5:
         begin
            range_unipolar = 1'b1;
            range_scale = ACRS_GAIN_X2P5;
         end
         ACRS_RNG_UNI_1P25:
         begin
            range_unipolar = 1'b1;
            range_scale = ACRS_GAIN_X1P25;
         end
         // Reserved codes fall back to the widest range so the input stays in scale.
         default: range_scale = ACRS_GAIN_X2P5;
      endcase
   end

   // ==========================================================
   // Output code with saturation on overrange
   always_comb
   begin
      code_nxt = code_r;
      code_v_nxt = conv_valid;
      sat_nxt = sat_r;
      if (conv_valid)
      begin
         sat_nxt = conv_over | conv_under;
         // Overrange wins when the front end flags both limits at once.
         if (conv_over)
            code_nxt = '1;
         else if (conv_under)
            code_nxt = '0;
         else
            code_nxt = conv_raw;
      end
   end

   // Saturation status keeps the last result's state until the next result arrives.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         code_r <= '0;
         code_v_r <= 1'b0;
         sat_r <= 1'b0;
      end
      else
      begin
         code_r <= code_nxt;
         code_v_r <= code_v_nxt;
         sat_r <= sat_nxt;
      end
   end

   // The code holds its last value between results; only the pulse marks fresh data.
   assign conv_code = code_r;
   assign conv_code_valid = code_v_r;
endmodule : acrs_sequencer

// ### verif/acrs_host_model.sv
// Behavioural host: chip-select frames carrying converter results.
`timescale 1ns/1ps
module acrs_host_model
(
   // Frame signals
   input wire logic hclk,
   output logic cs_n,
   output logic conv_valid,
   output logic [17:0] conv_raw,
   output logic conv_over,
   output logic conv_under
);
   import acrs_pkg::*;
   initial
   begin
      cs_n = 1'b1;
      conv_valid = 1'b0;
      conv_raw = 18'h0;
      conv_over = 1'b0;
      conv_under = 1'b0;
   end
   // Released result lines flip so a stale value never passes for a fresh one.
   task automatic frame(input logic [17:0] raw, input logic ov, input logic un, input int gap);
      cs_n <= 1'b0;
      repeat (gap) @(posedge hclk);
      conv_valid <= 1'b1;
      conv_raw <= raw;
      conv_over <= ov;
      conv_under <= un;
      @(posedge hclk);
      conv_valid <= 1'b0;
      conv_raw <= ~raw;
      conv_over <= ~ov;
      conv_under <= ~un;
      cs_n <= 1'b1;
      repeat (gap + 4) @(posedge hclk);
   endtask : frame
endmodule : acrs_host_model

// ### verif/acrs_sequencer_monitor.sv
// Port-level assertion checker for the channel range sequencer.
`timescale 1ns/1ps
module acrs_sequencer_monitor
#(
   parameter int CH_W = 3
)
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic cs_n,
   input wire logic reference_source_pin,
   input wire logic conv_valid,
   input wire logic [17:0] conv_raw,
   input wire logic conv_over,
   input wire logic conv_under,
   input wire logic [CH_W-1:0] mux_channel,
   input wire logic [3:0] channel_range_code,
   input wire logic range_unipolar,
   input wire logic [2:0] range_scale,
   input wire logic use_external_ref,
   input wire logic [17:0] conv_code,
   input wire logic conv_code_valid
);
   import acrs_pkg::*;
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // ==========================================================
   // Sequences
   sequence s_ref_steady;
      $stable(reference_source_pin) [*4];
   endsequence
   // ==========================================================
   // Assertions
   chk_reset_state: assert property ($rose(hresetn) |-> channel_range_code == 4'h0 && mux_channel == '0)
      else $error("range or channel not cleared");
   chk_scale_decode: assert property (range_scale == ((channel_range_code inside {4'h1, 4'h6}) ? 3'h2 :
      ((channel_range_code == 4'h2) ? 3'h4 : 3'h1))) else $error("scale decode wrong");
   chk_polarity_decode: assert property (range_unipolar == (channel_range_code inside {4'h5, 4'h6}))
      else $error("polarity decode wrong");
   chk_sat_high: assert property (conv_valid && conv_over |=> conv_code_valid && conv_code == '1)
      else $error("over range not saturated high");
   chk_sat_low: assert property (conv_valid && conv_under && !conv_over |=> conv_code == '0)
      else $error("under range not saturated low");
   chk_raw_pass: assert property (conv_valid && !conv_over && !conv_under |=> conv_code == $past(conv_raw))
      else $error("in range code altered");
   chk_ref_follow: assert property (s_ref_steady |-> use_external_ref == reference_source_pin)
      else $error("reference select not followed");
   chk_channel_step: assert property ($changed(mux_channel) |-> !$past(cs_n, 3) || !$past(cs_n, 4))
      else $error("channel moved without chip select fall");
endmodule : acrs_sequencer_monitor

bind acrs_sequencer acrs_sequencer_monitor #(.CH_W(CH_W)) u_mon (.hclk, .hresetn, .cs_n,
   .reference_source_pin, .conv_valid, .conv_raw, .conv_over, .conv_under, .mux_channel,
   .channel_range_code, .range_unipolar, .range_scale, .use_external_ref, .conv_code,
   .conv_code_valid);

// ### verif/acrs_sequencer_tb_top.sv
// Directed testbench for the channel range sequencer.
`timescale 1ns/1ps
module acrs_sequencer_tb_top;
   import acrs_pkg::*;
   localparam logic [3:0] CODES [5] = '{4'h0, 4'h1, 4'h2, 4'h5, 4'h6};
   logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic reference_source_pin = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
   logic hreadyout, hresp, cs_n, conv_valid, conv_over, conv_under, range_unipolar;
   logic use_external_ref, conv_code_valid;
   logic [2:0] mux_channel, range_scale;
   logic [3:0] channel_range_code;
   logic [17:0] conv_raw, conv_code, got_code = 18'h0;
   int error_cnt = 0, checks = 0;
   always #12.5 hclk = ~hclk;
   always @(posedge hclk) if (conv_code_valid === 1'b1) got_code <= conv_code;
   acrs_sequencer #(.NUM_CH(8), .CH_W(3)) dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
      .hsize, .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp, .cs_n,
      .reference_source_pin, .conv_valid, .conv_raw, .conv_over, .conv_under, .mux_channel,
      .channel_range_code, .range_unipolar, .range_scale, .use_external_ref, .conv_code,
      .conv_code_valid);
   acrs_host_model host (.hclk, .cs_n, .conv_valid, .conv_raw, .conv_over, .conv_under);
   // ==========================================================
   // Tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic test_done;
      $display("errors=%0d checks=%0d", error_cnt, checks);
      if (error_cnt == 0 && checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : test_done
   // Entered just after a rising edge; holds each phase until hready is seen high.
   task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] q);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= {20'h0, a};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask : bus
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask : wr
   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      chk(q, exp);
      chk(hresp, 32'h0);
   endtask : rd
   function automatic logic [2:0] nxt(input logic [2:0] c, input logic [7:0] en);
      for (int k = 1; k <= 8; k++)
         if (en[3'(c + k)]) return 3'(c + k);
      return c;
   endfunction : nxt
   // ==========================================================
   // Tests
   initial
   begin
      logic [2:0] ch;
      logic [3:0] c;
      logic [17:0] raw;
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      for (int i = 0; i < 8; i++)
         rd(ACRS_OFF_RANGE0 + 12'(4 * i), 32'h0);
      wr(12'h0FC, 32'hFFFF_FFFF);
      rd(12'h0FC, 32'h0);
      for (int i = 0; i < 8; i++)
         wr(ACRS_OFF_RANGE0 + 12'(4 * i), 32'(CODES[i % 5]));
      for (int i = 0; i < 8; i++)
         rd(ACRS_OFF_RANGE0 + 12'(4 * i), 32'(CODES[i % 5]));
      for (int i = 0; i < 8; i++)
      begin
         ch = 3'(7 - i);
         c = CODES[ch % 5];
         raw = 18'(i * 3001);
         wr(ACRS_OFF_MAN_CMD, 32'(ch));
         host.frame(raw, 1'b0, 1'b0, (i % 2) ? 6 : 1);
         chk(mux_channel, ch);
         chk(channel_range_code, c);
         chk(range_scale, (c inside {4'h1, 4'h6}) ? 3'h2 : ((c == 4'h2) ? 3'h4 : 3'h1));
         chk(range_unipolar, c inside {4'h5, 4'h6});
         chk(got_code, raw);
      end
      wr(ACRS_OFF_SCAN_EN, 32'hA5);
      wr(ACRS_OFF_CTRL, 32'h1);
      rd(ACRS_OFF_RATE, 32'(ACRS_TOTAL_KSPS / 4));
      rd(ACRS_OFF_STATUS, 32'h0410);
      for (int i = 0; i < 6; i++)
      begin
         ch = nxt(ch, 8'hA5);
         raw = 18'h2AAAA ^ 18'(i);
         host.frame(raw, i inside {1, 3}, i inside {2, 3}, 1);
         chk(mux_channel, ch);
         chk(got_code, (i inside {1, 3}) ? 18'h3FFFF : ((i == 2) ? 18'h0 : raw));
         if (i == 3)
            rd(ACRS_OFF_STATUS, 32'h0450);
      end
      wr(ACRS_OFF_SCAN_EN, 32'h08);
      rd(ACRS_OFF_RATE, 32'(ACRS_TOTAL_KSPS));
      host.frame(18'h1, 1'b0, 1'b0, 2);
      chk(mux_channel, 3'h3);
      reference_source_pin <= 1'b1;
      repeat (4) @(posedge hclk);
      chk(use_external_ref, 1'b1);
      rd(ACRS_OFF_STATUS, 32'h0133);
      reference_source_pin <= 1'b0;
      repeat (4) @(posedge hclk);
      chk(use_external_ref, 1'b0);
      wr(ACRS_OFF_SCAN_EN, 32'h0);
      rd(ACRS_OFF_RATE, 32'h0);
      host.frame(18'h2, 1'b0, 1'b0, 1);
      chk(mux_channel, 3'h3);
      chk(got_code, 18'h2);
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      chk(mux_channel, 3'h0);
      rd(ACRS_OFF_RANGE0 + 12'h00C, 32'h0);
      rd(ACRS_OFF_CTRL, 32'h0);
      test_done();
   end
   initial
   begin
      repeat (20000) @(posedge hclk);
      error_cnt++;
      test_done();
   end
endmodule : acrs_sequencer_tb_top
